// ==== src/flash_guard_pkg.sv ====
// constants for the flash region protection block
// Rules for this block and the software using it
// R1: multi-byte command parameters are big endian, high byte at lowest index
// R2: parameter bytes accept byte, aligned halfword and aligned word access
// R3: four 8-bit protection registers form one 32-bit region map
// R4: each bit covers 1/32 of flash, or 1 KB below 32 KB
// R5: upper registers are unused at 24, 16 and 8 KB or less
// R6: register 0 holds map bits 31:24 down to register 3 bits 7:0
// R7: reset sequence loads registers from config bytes 0x0B down to 0x08
// R8: program or erase inside a protected region is never allowed
// R9: restricted mode writes only take effect for one-to-zero bit changes
// R10: unrestricted mode lets every protection bit be written freely
// R11: software must not write protection registers while a command runs
// R12: a protected program or erase is rejected and sets the violation flag
// R13: whole block erase is refused if any region is protected
// R14: a zero bit means protected, a one bit means unprotected
// R15: software unprotects the config sector before reprogramming it
// R16: protection contents are undefined until the reset load completes
// R17: command complete stays low until the launched command finishes
// R18: a protection register read returns its current bits
package flash_guard_pkg;
   // register byte addresses
   localparam logic [7:0] ADDR_PARAM0    = 8'h00; // parameter bytes 0..11
   localparam logic [7:0] ADDR_PARAM_END = 8'h0C;
   localparam logic [7:0] ADDR_PROT0     = 8'h10; // protection regs 0..3
   localparam logic [7:0] ADDR_STATUS    = 8'h20; // event status, rd clears
   localparam logic [7:0] ADDR_MASK      = 8'h24; // interrupt mask
   localparam logic [7:0] ADDR_CTRL      = 8'h28; // launch / state
   // config byte offset of protection register 0, others descend
   localparam logic [3:0] CFG_PROT0_OFS  = 4'hB;
   localparam logic [3:0] CFG_PROT3_OFS  = 4'h8;
   // event status bit positions
   localparam int EV_DONE = 0;
   localparam int EV_VIOL = 1;
   localparam int EV_W    = 2;
   // control / status bit positions
   localparam int CT_LAUNCH = 0; // write 1: launch command
   localparam int CT_COMMAND_COMPLETE_FLAG   = 1; // read: command complete
   localparam int CT_VIOL   = 2; // read: violation flag, write 1 clears
   localparam int CT_SPEC   = 3; // read: unrestricted mode
   localparam int CT_LOADED = 4; // read: reset load done
   // operation codes in parameter byte 0
   localparam logic [7:0] OP_PROGRAM = 8'h06;
   localparam logic [7:0] OP_ERASE   = 8'h09;
   localparam logic [7:0] OP_ERASEALL= 8'h44;
   localparam int KB = 1024;
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;
   typedef enum logic [1:0] {
      ST_LOAD = 2'b00,
      ST_IDLE = 2'b01,
      ST_EXEC = 2'b10
   } cmd_state_t;
endpackage : flash_guard_pkg

// ==== src/flash_guard.sv ====
// flash region protection with wishbone register slave
`timescale 1ns/1ns
module flash_guard #(
   parameter int FLASH_KB  = 32, // program flash size in kbytes
   parameter int EXEC_CYC  = 8   // cycles a passed command runs
) (
   input  wire logic        clk_sys,
   input  wire logic        reset_n,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   output logic             wb_err_o,
   output logic             cfg_rd_o,   // config byte fetch strobe
   output logic      [3:0]  cfg_ofs_o,  // config byte offset
   input  wire logic [7:0]  cfg_data_i, // byte, valid cycle after strobe
   input  wire logic        unrestricted_mode,
   output logic             command_complete_flag,
   output logic             guard_violation_flag,
   output logic             irq_o
);
   initial begin
      if (FLASH_KB < 8 || FLASH_KB > 32 || (FLASH_KB % 8) != 0)
         $error("FLASH_KB must be 8, 16, 24 or 32");
      if (EXEC_CYC < 1 || EXEC_CYC > 255)
         $error("EXEC_CYC out of range");
   end

   // the block sits between software, the command engine and the array:
   // - software fills the parameter bytes, then launches through ctrl
   // - the protection check runs in the launch cycle, so a refused
   //   command never reaches the array and finishes one cycle later
   // - a passed command is modelled as a fixed busy time of EXEC_CYC
   // - the map is loaded once after reset from four config bytes
   // - writes to the map obey the mode pin, restricted writes only
   //   ever close regions
   // limitation: parameter and map writes during a command are dropped
   // silently rather than answered with err, as software is expected
   // to poll the complete flag before touching them
   // trade-off: word decode keeps the bus logic small; byte addresses
   // are expressed through the lane enables instead

   // event bit positions, local copies for packed widths below
   localparam int EV_DONE = flash_guard_pkg::EV_DONE;
   localparam int EV_VIOL = flash_guard_pkg::EV_VIOL;
   localparam int EV_W    = flash_guard_pkg::EV_W;

   // number of protection registers in use (R5)
   localparam int NREG = FLASH_KB / 8; // R5
   localparam logic [7:0] EXEC_N = 8'(EXEC_CYC);

   logic [7:0]  param_r [0:11];
   logic [31:0] region_guard_bits_r; // R3
   logic [EV_W-1:0] ev_status_r, ev_mask_r;
   flash_guard_pkg::cmd_state_t state_r;
   logic [2:0]  load_idx_r;
   logic        load_pend_r;
   logic [7:0]  exec_cnt_r;
   logic        req_r;
   logic        ack_pulse;
   logic        wr, rd;
   logic [7:0]  a;
   logic [31:0] rdata_nxt;

   // word address of the access: bus address with its low two bits cleared
   assign a   = {wb_adr_i[7:2], 2'b00};
   assign req_r = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
   assign wr  = req_r & wb_we_i & ack_pulse;
   assign rd  = req_r & ~wb_we_i & ack_pulse;

   // tell whether an address hits the protection register word
   function automatic logic is_region_guard_bits(input logic [7:0] ad);
      return ad == flash_guard_pkg::ADDR_PROT0;
   endfunction : is_region_guard_bits

   // legal byte-enable patterns: byte, aligned half, full word (R2)
   function automatic logic sel_ok(input logic [3:0] s);
      case (s)
         4'b0001, 4'b0010, 4'b0100, 4'b1000,
         4'b0011, 4'b1100, 4'b1111: sel_ok = 1'b1; // R2
         default:                   sel_ok = 1'b0;
      endcase
   endfunction : sel_ok

   // mapped decode
   function automatic logic mapped(input logic [7:0] ad);
      return (ad < flash_guard_pkg::ADDR_PARAM_END) || is_region_guard_bits(ad) ||
             ad == flash_guard_pkg::ADDR_STATUS ||
             ad == flash_guard_pkg::ADDR_MASK ||
             ad == flash_guard_pkg::ADDR_CTRL;
   endfunction : mapped

   assign ack_pulse = mapped(a) & sel_ok(wb_sel_i);

   // bus answer: ack or err one cycle after request, dropped next cycle
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= req_r & ack_pulse;
         wb_err_o <= req_r & ~ack_pulse;
         wb_dat_o <= (req_r & ack_pulse & ~wb_we_i) ? rdata_nxt
                                                    : 32'h0000_0000;
      end
   end

   // read mux; byte n of a word sits on lane 3-n, big endian (R1)
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      if (a < flash_guard_pkg::ADDR_PARAM_END)
         rdata_nxt = {param_r[a[3:0]], param_r[a[3:0]+4'd1],
                      param_r[a[3:0]+4'd2], param_r[a[3:0]+4'd3]}; // R1
      else if (is_region_guard_bits(a))
         rdata_nxt = region_guard_bits_r; // R6 R18
      else if (a == flash_guard_pkg::ADDR_STATUS)
         rdata_nxt = {30'h0, ev_status_r};
      else if (a == flash_guard_pkg::ADDR_MASK)
         rdata_nxt = {30'h0, ev_mask_r};
      else if (a == flash_guard_pkg::ADDR_CTRL)
         rdata_nxt = {27'h0, state_r != flash_guard_pkg::ST_LOAD,
                      unrestricted_mode, guard_violation_flag,
                      command_complete_flag, 1'b0};
   end

   // parameter bytes; writes ignored while a command runs
   genvar gi;
   generate
      for (gi = 0; gi < 12; gi++) begin : g_param
         always_ff @(posedge clk_sys) begin
            if (!reset_n)
               param_r[gi] <= 8'h00;
            else if (wr && a == 8'(gi & ~3) && wb_sel_i[3 - (gi % 4)] &&
                     command_complete_flag)
               param_r[gi] <= wb_dat_i[8*(3-(gi%4)) +: 8]; // R1 R2
         end
      end
   endgenerate

   // decode the target region of the parameter address
   logic [23:0] tgt_addr;
   logic [4:0]  tgt_region;
   logic        tgt_open, all_open, viol_nxt;
   logic [7:0]  op;
   assign op       = param_r[0];
   assign tgt_addr = {param_r[1], param_r[2], param_r[3]}; // R1
   // region size: 1/32 of flash, 1 KB below 32 KB (R4)
   assign tgt_region = (FLASH_KB < 32) ? 5'(tgt_addr / flash_guard_pkg::KB)
                     : 5'(tgt_addr / (FLASH_KB * flash_guard_pkg::KB / 32));
   assign tgt_open = region_guard_bits_r[tgt_region]; // R14
   // only assigned bits count for the whole-block erase (R5)
   assign all_open = &region_guard_bits_r[8*NREG-1:0]; // R13
   always_comb begin
      viol_nxt = 1'b0;
      if ((op == flash_guard_pkg::OP_PROGRAM ||
           op == flash_guard_pkg::OP_ERASE) && !tgt_open)
         viol_nxt = 1'b1; // R8 R12
      else if (op == flash_guard_pkg::OP_ERASEALL && !all_open)
         viol_nxt = 1'b1; // R13
   end

   logic launch, viol_clr;
   assign launch   = wr && a == flash_guard_pkg::ADDR_CTRL && wb_sel_i[0] &&
                     wb_dat_i[flash_guard_pkg::CT_LAUNCH];
   assign viol_clr = wr && a == flash_guard_pkg::ADDR_CTRL && wb_sel_i[0] &&
                     wb_dat_i[flash_guard_pkg::CT_VIOL];

   // command sequencing, reset load first (R7 R16 R17)
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         state_r               <= flash_guard_pkg::ST_LOAD;
         load_idx_r            <= 3'd0;
         load_pend_r           <= 1'b0;
         exec_cnt_r            <= 8'h00;
         command_complete_flag <= 1'b0; // R16
         guard_violation_flag  <= 1'b0;
         cfg_rd_o              <= 1'b0;
         cfg_ofs_o             <= 4'h0;
      end else begin
         cfg_rd_o <= 1'b0;
         if (viol_clr && !(launch && viol_nxt))
            guard_violation_flag <= 1'b0;
         case (state_r)
            flash_guard_pkg::ST_LOAD: begin
               load_pend_r <= cfg_rd_o;
               if (load_pend_r)
                  load_idx_r <= load_idx_r + 3'd1;
               if (!cfg_rd_o && !load_pend_r) begin
                  if (load_idx_r == 3'd4) begin
                     state_r               <= flash_guard_pkg::ST_IDLE;
                     command_complete_flag <= 1'b1;
                  end else begin
                     cfg_rd_o  <= 1'b1;
                     cfg_ofs_o <= flash_guard_pkg::CFG_PROT0_OFS -
                                  {2'b00, load_idx_r[1:0]}; // R7
                  end
               end
            end
            flash_guard_pkg::ST_IDLE: begin
               // blocked while the violation flag stands
               if (launch && !guard_violation_flag) begin
                  command_complete_flag <= 1'b0; // R17
                  if (viol_nxt) begin
                     guard_violation_flag <= 1'b1; // R12
                     exec_cnt_r <= 8'd1;
                  end else
                     exec_cnt_r <= EXEC_N;
                  state_r <= flash_guard_pkg::ST_EXEC;
               end
            end
            flash_guard_pkg::ST_EXEC: begin
               exec_cnt_r <= exec_cnt_r - 8'd1;
               if (exec_cnt_r == 8'd1) begin
                  command_complete_flag <= 1'b1; // R17
                  state_r               <= flash_guard_pkg::ST_IDLE;
               end
            end
            default: state_r <= flash_guard_pkg::ST_IDLE;
         endcase
      end
   end

   // protection map: reset load, then mode-dependent writes; one process
   // for all four registers so the 32-bit map keeps a single driver
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         region_guard_bits_r <= flash_guard_pkg::RESET_WORD; // R16
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (state_r == flash_guard_pkg::ST_LOAD) begin
               if (load_pend_r && load_idx_r == 3'(i))
                  region_guard_bits_r[8*(3-i) +: 8] <= cfg_data_i; // R6 R7
            end else if (wr && is_region_guard_bits(a) && wb_sel_i[3-i] &&
                         command_complete_flag) begin // R11
               if (unrestricted_mode)
                  region_guard_bits_r[8*(3-i) +: 8] <=
                     wb_dat_i[8*(3-i) +: 8]; // R10
               else
                  region_guard_bits_r[8*(3-i) +: 8] <=
                     region_guard_bits_r[8*(3-i) +: 8] &
                     wb_dat_i[8*(3-i) +: 8]; // R9
            end
         end
      end
   end

   // sticky events; set beats the read clear
   logic [EV_W-1:0] ev_set;
   logic            done_edge;
   assign done_edge = state_r == flash_guard_pkg::ST_EXEC &&
                      exec_cnt_r == 8'd1;
   assign ev_set = {launch && !guard_violation_flag &&
                    state_r == flash_guard_pkg::ST_IDLE && viol_nxt,
                    done_edge};
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         ev_status_r <= '0;
         ev_mask_r   <= '0;
         irq_o       <= 1'b0;
      end else begin
         if (rd && a == flash_guard_pkg::ADDR_STATUS)
            ev_status_r <= ev_set;
         else
            ev_status_r <= ev_status_r | ev_set;
         if (wr && a == flash_guard_pkg::ADDR_MASK && wb_sel_i[0])
            ev_mask_r <= wb_dat_i[EV_W-1:0];
         irq_o <= |(ev_status_r & ev_mask_r);
      end
   end

   // restricted writes never clear protection
   a_restrict_only: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (state_r != flash_guard_pkg::ST_LOAD && !unrestricted_mode)
      |=> (region_guard_bits_r & ~$past(region_guard_bits_r)) == 32'h0)
      else $error("protection bit raised in restricted mode"); // R9
   a_free_write: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (wr && is_region_guard_bits(a) && wb_sel_i == 4'hF && unrestricted_mode &&
       command_complete_flag && state_r == flash_guard_pkg::ST_IDLE)
      |=> region_guard_bits_r == $past(wb_dat_i))
      else $error("unrestricted write not taken"); // R10
   a_viol_set: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (state_r == flash_guard_pkg::ST_IDLE && launch &&
       !guard_violation_flag && viol_nxt)
      |=> guard_violation_flag && !command_complete_flag ##1
          command_complete_flag)
      else $error("violation not flagged"); // R12
   a_command_complete_flag_low: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (state_r == flash_guard_pkg::ST_IDLE && launch &&
       !guard_violation_flag && !viol_nxt)
      |=> !command_complete_flag [*1] ##0 state_r == flash_guard_pkg::ST_EXEC)
      else $error("complete flag did not drop"); // R17
   a_load_order: assert property (@(posedge clk_sys) disable iff (!reset_n)
      cfg_rd_o |-> cfg_ofs_o <= flash_guard_pkg::CFG_PROT0_OFS &&
                   cfg_ofs_o >= flash_guard_pkg::CFG_PROT3_OFS)
      else $error("config offset out of range"); // R7
   a_no_erase_all: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (op == flash_guard_pkg::OP_ERASEALL && !all_open) |-> viol_nxt)
      else $error("block erase not refused"); // R13
   a_region_guard_bits_read: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (rd && is_region_guard_bits(a)) |=> wb_ack_o && wb_dat_o == $past(region_guard_bits_r))
      else $error("protection read wrong"); // R18
   a_open_ok: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (op == flash_guard_pkg::OP_PROGRAM && tgt_open) |-> !viol_nxt)
      else $error("open region refused"); // R8

   // a closed target always means a refusal for program and erase
   a_closed_viol: assert property (@(posedge clk_sys) disable iff (!reset_n)
      ((op == flash_guard_pkg::OP_PROGRAM ||
        op == flash_guard_pkg::OP_ERASE) && !tgt_open) |-> viol_nxt)
      else $error("closed region not refused"); // R8 R14

   // every region is one kbyte at the sizes served here
   a_region_size: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (op == flash_guard_pkg::OP_PROGRAM) |-> tgt_region == tgt_addr[14:10])
      else $error("target region decode wrong"); // R4

   // a bus answer lasts one cycle only
   a_ack_pulse: assert property (@(posedge clk_sys) disable iff (!reset_n)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held past one cycle"); // R2

   // refused lane patterns answer with err and never ack
   a_bad_sel: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (req_r && !sel_ok(wb_sel_i)) |=> wb_err_o && !wb_ack_o)
      else $error("illegal byte enables not refused"); // R2

   // a parameter word reads back with byte 0 on the top lane
   a_param_endian: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (rd && a == flash_guard_pkg::ADDR_PARAM0)
      |=> wb_dat_o[31:24] == $past(param_r[0]))
      else $error("parameter byte order wrong"); // R1

   // the first fetched byte lands in the top register only
   a_load_lane: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (state_r == flash_guard_pkg::ST_LOAD && load_pend_r &&
       load_idx_r == 3'd0)
      |=> region_guard_bits_r[31:24] == $past(cfg_data_i))
      else $error("register 0 not loaded"); // R6 R7

   // nothing may launch before the map is known
   a_load_busy: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (state_r == flash_guard_pkg::ST_LOAD) |-> !command_complete_flag)
      else $error("complete flag high during load"); // R16

   // the finishing cycle of a command leaves its done event behind
   a_done_event: assert property (@(posedge clk_sys) disable iff (!reset_n)
      done_edge |=> ev_status_r[EV_DONE])
      else $error("done event lost"); // R17

   // an unmasked pending event raises the line one cycle later
   a_irq_level: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (|(ev_status_r & ev_mask_r)) |=> irq_o)
      else $error("interrupt not raised");
endmodule : flash_guard

// ==== sim/cfg_store.sv ====
// config byte store that answers the block's reset-time fetches
`timescale 1ns/1ns
module cfg_store #(
   parameter logic [7:0] PROT0_BYTE = 8'hFF,
   parameter logic [7:0] PROT1_BYTE = 8'hF7,
   parameter logic [7:0] PROT2_BYTE = 8'h3C,
   parameter logic [7:0] PROT3_BYTE = 8'hA5
) (
   input  wire logic       clk_sys,
   input  wire logic       cfg_rd,
   input  wire logic [3:0] cfg_ofs,
   output logic      [7:0] cfg_data
);
   logic [7:0] byte_nxt;

   // protection bytes sit at 0x8..0xB, register 0 at the highest offset
   always_comb begin
      case (cfg_ofs)
         4'hB:    byte_nxt = PROT0_BYTE;
         4'hA:    byte_nxt = PROT1_BYTE;
         4'h9:    byte_nxt = PROT2_BYTE;
         4'h8:    byte_nxt = PROT3_BYTE;
         default: byte_nxt = 8'h00;
      endcase
   end

   // byte stands one cycle only; otherwise the lines flip every cycle
   // so a sample an odd number of cycles late reads the inverted byte
   initial cfg_data = 8'h00;
   always @(posedge clk_sys) begin
      if (cfg_rd) begin
         cfg_data <= byte_nxt;
      end else begin
         cfg_data <= ~cfg_data;
      end
   end
endmodule : cfg_store

// ==== sim/testbench.sv ====
// self-checking bench for the flash region protection block
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin \
   fail_count++; $display("MISMATCH %s expected %h seen %h", nm, exp, \
   got); end end
module testbench;
   logic        clk_sys           = 1'b0;
   logic        reset_n           = 1'b0;
   logic        wb_cyc_i          = 1'b0;
   logic        wb_stb_i          = 1'b0;
   logic        wb_we_i           = 1'b0;
   logic [7:0]  wb_adr_i          = 8'h00;
   logic [3:0]  wb_sel_i          = 4'h0;
   logic [31:0] wb_dat_i          = 32'h0000_0000;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic        wb_err_o;
   logic        cfg_rd_o;
   logic [3:0]  cfg_ofs_o;
   logic [7:0]  cfg_data_i;
   logic        unrestricted_mode = 1'b0;
   logic        command_complete_flag;
   logic        guard_violation_flag;
   logic        irq_o;
   logic        bus_err;
   int          fail_count        = 0;
   int          n_checks          = 0;

   always #25 clk_sys = ~clk_sys;

   flash_guard #(.FLASH_KB(32), .EXEC_CYC(8)) u_flash_guard (
      .clk_sys(clk_sys), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .cfg_rd_o(cfg_rd_o),
      .cfg_ofs_o(cfg_ofs_o), .cfg_data_i(cfg_data_i),
      .unrestricted_mode(unrestricted_mode),
      .command_complete_flag(command_complete_flag),
      .guard_violation_flag(guard_violation_flag), .irq_o(irq_o));

   cfg_store u_cfg_store (.clk_sys(clk_sys), .cfg_rd(cfg_rd_o),
      .cfg_ofs(cfg_ofs_o), .cfg_data(cfg_data_i));

   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : complete_run

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : tick

   // one classic cycle: hold everything until ack or err is seen high
   task automatic xfer(input logic we, input logic [7:0] a,
         input logic [3:0] s, input logic [31:0] d, output logic [31:0] q);
      int k;
      @(posedge clk_sys);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_sel_i <= s;
      wb_dat_i <= d;
      for (k = 0; k < 20; k++) begin
         @(posedge clk_sys);
         if (wb_ack_o === 1'b1 || wb_err_o === 1'b1) break;
      end
      q = wb_dat_o;
      bus_err = wb_err_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
      if (k == 20) begin
         fail_count++;
         complete_run();
      end
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [3:0] s,
                     input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, s, d, q);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      xfer(1'b0, a, 4'hF, 32'h0000_0000, q);
   endtask : rd

   // bounded wait for the command to finish
   task automatic wait_command_complete_flag();
      int k;
      for (k = 0; k < 60; k++) begin
         @(posedge clk_sys);
         if (command_complete_flag === 1'b1) break;
      end
      if (k == 60) begin
         fail_count++;
         complete_run();
      end
   endtask : wait_command_complete_flag

   task automatic run_cmd(input logic [7:0] op, input logic [23:0] adr,
                          input logic vexp);
      wr(flash_guard_pkg::ADDR_PARAM0, 4'hF, {op, adr});
      wr(flash_guard_pkg::ADDR_CTRL, 4'hF, 32'h0000_0001);
      tick(1);
      if (!vexp) `CHK("command_complete_flag busy", 1'b0, command_complete_flag)
      wait_command_complete_flag();
      tick(2);
      `CHK("violation", vexp, guard_violation_flag)
   endtask : run_cmd

   initial begin
      logic [31:0] q;
      tick(4);
      reset_n <= 1'b1;
      wait_command_complete_flag();
      rd(flash_guard_pkg::ADDR_CTRL, q);
      `CHK("loaded", 1'b1, q[flash_guard_pkg::CT_LOADED])
      rd(flash_guard_pkg::ADDR_PROT0, q);
      `CHK("region_guard_bits load", 32'hFFF7_3CA5, q)
      // restricted mode: only one-to-zero changes land
      wr(flash_guard_pkg::ADDR_PROT0, 4'hF, 32'h0F0F_FF5A);
      rd(flash_guard_pkg::ADDR_PROT0, q);
      `CHK("restricted", 32'h0F07_3C00, q)
      wr(flash_guard_pkg::ADDR_PROT0, 4'hF, 32'hFFFF_FFFF);
      rd(flash_guard_pkg::ADDR_PROT0, q);
      `CHK("no unprotect", 32'h0F07_3C00, q)
      unrestricted_mode <= 1'b1;
      wr(flash_guard_pkg::ADDR_PROT0, 4'hF, 32'hFFFF_FFFF);
      rd(flash_guard_pkg::ADDR_PROT0, q);
      `CHK("unrestricted", 32'hFFFF_FFFF, q)
      wr(flash_guard_pkg::ADDR_PROT0, 4'b0100, 32'h005A_0000);
      rd(flash_guard_pkg::ADDR_PROT0, q);
      `CHK("byte lane", 32'hFF5A_FFFF, q)
      // illegal lanes and a hole in the map are refused
      wr(flash_guard_pkg::ADDR_PROT0, 4'b0101, 32'h0000_0000);
      `CHK("bad sel", 1'b1, bus_err)
      rd(8'h30, q);
      `CHK("unmapped", 1'b1, bus_err)
      rd(flash_guard_pkg::ADDR_PROT0, q);
      `CHK("refused kept", 32'hFF5A_FFFF, q)
      // parameter bytes: big endian, byte and halfword lanes
      wr(8'h04, 4'hF, 32'h1122_3344);
      wr(8'h04, 4'b0010, 32'h0000_AB00);
      wr(8'h04, 4'b1100, 32'h5566_0000);
      rd(8'h04, q);
      `CHK("param bytes", 32'h5566_AB44, q)
      // region 0 (first kbyte) protected
      wr(flash_guard_pkg::ADDR_PROT0, 4'hF, 32'hFFFF_FFFE);
      run_cmd(flash_guard_pkg::OP_PROGRAM, 24'h00_0100, 1'b1);
      `CHK("irq masked", 1'b0, irq_o)
      rd(flash_guard_pkg::ADDR_STATUS, q);
      `CHK("viol event", 1'b1, q[flash_guard_pkg::EV_VIOL])
      rd(flash_guard_pkg::ADDR_STATUS, q);
      `CHK("read clears", 1'b0, q[flash_guard_pkg::EV_VIOL])
      wr(flash_guard_pkg::ADDR_CTRL, 4'hF, 32'h0000_0004);
      wr(flash_guard_pkg::ADDR_MASK, 4'hF, 32'h0000_0002);
      run_cmd(flash_guard_pkg::OP_ERASEALL, 24'h00_0000, 1'b1);
      `CHK("irq raised", 1'b1, irq_o)
      rd(flash_guard_pkg::ADDR_STATUS, q);
      tick(2);
      `CHK("irq cleared", 1'b0, irq_o)
      wr(flash_guard_pkg::ADDR_CTRL, 4'hF, 32'h0000_0004);
      run_cmd(flash_guard_pkg::OP_PROGRAM, 24'h00_0400, 1'b0);
      run_cmd(flash_guard_pkg::OP_ERASE, 24'h00_0800, 1'b0);
      // a protection write while a command runs must not land
      wr(flash_guard_pkg::ADDR_PARAM0, 4'hF, 32'h0600_0C00);
      wr(flash_guard_pkg::ADDR_CTRL, 4'hF, 32'h0000_0001);
      wr(flash_guard_pkg::ADDR_PROT0, 4'hF, 32'h0000_0000);
      wait_command_complete_flag();
      rd(flash_guard_pkg::ADDR_PROT0, q);
      `CHK("busy write", 32'hFFFF_FFFE, q)
      wr(flash_guard_pkg::ADDR_PROT0, 4'hF, 32'hFFFF_FFFF);
      run_cmd(flash_guard_pkg::OP_ERASEALL, 24'h00_0000, 1'b0);
      // config sector opened above, so its protection byte may be rewritten
      run_cmd(flash_guard_pkg::OP_PROGRAM, 24'h00_0008, 1'b0);
      complete_run();
   end
endmodule : testbench
